// >>> design/ifp_pkg.sv
// Constants shared by the frame assembly and checking path
package ifp_pkg;
   // ==========================================================
   // Framing
   localparam int unsigned PREAMBLE_LEN = 4;
   localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
   localparam logic [7:0] SFD_BYTE = 8'ha7;
   localparam logic [6:0] FCS_LEN = 7'h02;
   localparam logic [6:0] LEN_MIN = 7'h02;
   localparam int unsigned MAX_FRAME = 128;
   // ==========================================================
   // Frame check sum, reflected form of x^16+x^12+x^5+1
   localparam logic [15:0] CRC_POLY_REV = 16'h8408;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;
   // ==========================================================
   // Reference header and length values of typical senders
   localparam logic [15:0] REF_FRAME_CTRL = 16'h0801;
   localparam logic [15:0] REF_BCAST = 16'hffff;
   localparam logic [7:0] REF_LEN_SEC_COMM = 8'h2a;
   localparam logic [7:0] REF_LEN_SEC_DATA = 8'h18;
   localparam logic [7:0] REF_LEN_STD_COMM = 8'h11;
   localparam logic [7:0] REF_LEN_STD_DATA = 8'h0f;
   localparam logic [15:0] REF_PAYLOAD_CTRL = 16'h308c;
   // ==========================================================
   // States
   typedef enum logic [2:0] {
      TX_IDLE, TX_PRE, TX_SFD, TX_LEN, TX_BODY, TX_FCS_LO, TX_FCS_HI
   } ifp_tx_st_t;
   typedef enum logic [1:0] {RX_HUNT, RX_LEN, RX_BODY, RX_FWD} ifp_rx_st_t;
endpackage : ifp_pkg

// >>> design/ifp_frame_path.sv
// Frame assembly, check sum and forwarding path of the radio
`timescale 1ns/10ps
// Overview of operation
// - Multi-byte fields travel least significant byte first
// - Transmit starts with four zero preamble bytes
// - Send 0xA7 start byte; find frames by it
// - Length byte counts all following bytes, sum included
// - Two-byte CRC16 trailer over length onward
// - Device computes and appends sum on transmit
// - Received frame with bad sum dropped; rx_drop pulses for one cycle
// - Received frame with good sum goes to host
// - Forward length through payload, no framing or sum
module ifp_frame_path
   import ifp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] phy_tx_data,
   output logic phy_tx_valid,
   output logic phy_tx_last,
   input wire logic phy_tx_ready,
   input wire logic [7:0] phy_rx_data,
   input wire logic phy_rx_valid,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_last,
   input wire logic rx_ready,
   output logic rx_drop
);
   // ==========================================================
   // Check sum step, one byte, bit 0 first
   function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ b[i]) begin
            c = (c >> 1) ^ CRC_POLY_REV;
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction : crc_byte

   // ==========================================================
   // Transmit side
   ifp_tx_st_t tx_st_q, tx_st_d;
   logic [1:0] pre_cnt_q;
   logic [6:0] tx_rem_q;
   logic [15:0] tx_crc_q;
   logic tx_ready_q;
   logic [7:0] phy_tx_data_q;
   logic phy_tx_valid_q, phy_tx_last_q;
   logic out_free, take, load, load_last;
   logic [7:0] load_data;

   assign out_free = !phy_tx_valid_q || phy_tx_ready;
   assign take = tx_valid && tx_ready_q;

   always_comb begin
      tx_st_d = tx_st_q;
      load = 1'b0;
      load_last = 1'b0;
      load_data = PREAMBLE_BYTE;
      unique case (tx_st_q)
         TX_IDLE: begin
            if (tx_valid) begin
               tx_st_d = TX_PRE;
            end
         end
         TX_PRE: begin
            load = out_free;
            load_data = PREAMBLE_BYTE;
            if (out_free && pre_cnt_q == 2'(PREAMBLE_LEN - 1)) begin
               tx_st_d = TX_SFD;
            end
         end
         TX_SFD: begin
            load = out_free;
            load_data = SFD_BYTE;
            if (out_free) begin
               tx_st_d = TX_LEN;
            end
         end
         TX_LEN: begin
            load = take;
            load_data = tx_data;
            if (take) begin
               tx_st_d = (tx_data[6:0] <= LEN_MIN) ? TX_FCS_LO : TX_BODY;
            end
         end
         TX_BODY: begin
            load = take;
            load_data = tx_data;
            if (take && tx_rem_q == 7'h01) begin
               tx_st_d = TX_FCS_LO;
            end
         end
         TX_FCS_LO: begin
            load = out_free;
            load_data = tx_crc_q[7:0];
            if (out_free) begin
               tx_st_d = TX_FCS_HI;
            end
         end
         TX_FCS_HI: begin
            load = out_free;
            load_last = 1'b1;
            load_data = tx_crc_q[15:8];
            if (out_free) begin
               tx_st_d = TX_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_st_q <= TX_IDLE;
         pre_cnt_q <= 2'h0;
         tx_rem_q <= 7'h00;
         tx_crc_q <= CRC_INIT;
      end else begin
         tx_st_q <= tx_st_d;
         if (tx_st_q == TX_PRE && out_free) begin
            pre_cnt_q <= pre_cnt_q + 2'h1;
         end else if (tx_st_q != TX_PRE) begin
            pre_cnt_q <= 2'h0;
         end
         if (tx_st_q == TX_LEN && take) begin
            tx_rem_q <= tx_data[6:0] - FCS_LEN;
            tx_crc_q <= crc_byte(CRC_INIT, tx_data);
         end else if (tx_st_q == TX_BODY && take) begin
            tx_rem_q <= tx_rem_q - 7'h01;
            tx_crc_q <= crc_byte(tx_crc_q, tx_data);
         end
      end
   end

   // Host is only offered a slot when the output stage is sure to be empty
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready_q <= 1'b0;
      end else begin
         tx_ready_q <= (tx_st_d == TX_LEN || tx_st_d == TX_BODY) && !load && out_free;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phy_tx_valid_q <= 1'b0;
         phy_tx_data_q <= 8'h00;
         phy_tx_last_q <= 1'b0;
      end else if (load) begin
         phy_tx_valid_q <= 1'b1;
         phy_tx_data_q <= load_data;
         phy_tx_last_q <= load_last;
      end else if (phy_tx_ready) begin
         phy_tx_valid_q <= 1'b0;
         phy_tx_last_q <= 1'b0;
      end
   end

   // ==========================================================
   // Receive side
   // Whole frame is held until its sum is known; radio bytes arriving
   // while a good frame is still being forwarded are ignored.
   ifp_rx_st_t rx_st_q;
   logic [7:0] frame_mem [MAX_FRAME];
   logic [6:0] wr_idx_q, rd_idx_q, rx_rem_q;
   logic [15:0] rx_crc_q, rx_crc_nx;
   logic rx_drop_q;
   logic push, push_last, spare_valid_q, spare_last_q;
   logic [7:0] push_data, spare_data_q;

   assign rx_crc_nx = crc_byte(rx_crc_q, phy_rx_data);
   assign push = (rx_st_q == RX_FWD) && !spare_valid_q;
   assign push_data = frame_mem[rd_idx_q];
   assign push_last = (rd_idx_q == wr_idx_q - 7'h01);

   always_ff @(posedge clock) begin
      if (phy_rx_valid && (rx_st_q == RX_LEN || rx_st_q == RX_BODY)) begin
         frame_mem[wr_idx_q] <= phy_rx_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_q <= RX_HUNT;
         wr_idx_q <= 7'h00;
         rd_idx_q <= 7'h00;
         rx_rem_q <= 7'h00;
         rx_crc_q <= CRC_INIT;
         rx_drop_q <= 1'b0;
      end else begin
         rx_drop_q <= 1'b0;
         unique case (rx_st_q)
            RX_HUNT: begin
               wr_idx_q <= 7'h00;
               rd_idx_q <= 7'h00;
               if (phy_rx_valid && phy_rx_data == SFD_BYTE) begin
                  rx_st_q <= RX_LEN;
               end
            end
            RX_LEN: begin
               if (phy_rx_valid) begin
                  rx_crc_q <= crc_byte(CRC_INIT, phy_rx_data);
                  rx_rem_q <= phy_rx_data[6:0];
                  wr_idx_q <= 7'h01;
                  if (phy_rx_data[6:0] < LEN_MIN) begin
                     rx_st_q <= RX_HUNT;
                     rx_drop_q <= 1'b1;
                  end else begin
                     rx_st_q <= RX_BODY;
                  end
               end
            end
            RX_BODY: begin
               if (phy_rx_valid) begin
                  rx_crc_q <= rx_crc_nx;
                  rx_rem_q <= rx_rem_q - 7'h01;
                  // Sum bytes do not advance the write index, so they never reach the host
                  if (rx_rem_q > FCS_LEN) begin
                     wr_idx_q <= wr_idx_q + 7'h01;
                  end
                  if (rx_rem_q == 7'h01) begin
                     if (rx_crc_nx == CRC_RESIDUE) begin
                        rx_st_q <= RX_FWD;
                     end else begin
                        rx_st_q <= RX_HUNT;
                        rx_drop_q <= 1'b1;
                     end
                  end
               end
            end
            RX_FWD: begin
               if (push) begin
                  rd_idx_q <= rd_idx_q + 7'h01;
                  if (push_last) begin
                     rx_st_q <= RX_HUNT;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Two-entry host buffer: output stage plus one spare
   logic [7:0] rx_data_q;
   logic rx_valid_q, rx_last_q, pop;
   assign pop = rx_valid_q && rx_ready;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_valid_q <= 1'b0;
         rx_data_q <= 8'h00;
         rx_last_q <= 1'b0;
         spare_valid_q <= 1'b0;
         spare_data_q <= 8'h00;
         spare_last_q <= 1'b0;
      end else if (!rx_valid_q || pop) begin
         if (spare_valid_q) begin
            rx_valid_q <= 1'b1;
            rx_data_q <= spare_data_q;
            rx_last_q <= spare_last_q;
            spare_valid_q <= push;
            spare_data_q <= push_data;
            spare_last_q <= push_last;
         end else begin
            rx_valid_q <= push;
            rx_data_q <= push_data;
            // Gated so a stale index match never marks an empty slot
            rx_last_q <= push && push_last;
         end
      end else if (push) begin
         spare_valid_q <= 1'b1;
         spare_data_q <= push_data;
         spare_last_q <= push_last;
      end
   end

   assign tx_ready = tx_ready_q;
   assign phy_tx_data = phy_tx_data_q;
   assign phy_tx_valid = phy_tx_valid_q;
   assign phy_tx_last = phy_tx_last_q;
   assign rx_data = rx_data_q;
   assign rx_valid = rx_valid_q;
   assign rx_last = rx_last_q;
   assign rx_drop = rx_drop_q;
endmodule : ifp_frame_path

// >>> dv/ifp_frame_path_properties.sv
// Port checker of the frame path
`timescale 1ns/10ps
module ifp_frame_path_properties
   import ifp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] phy_tx_data,
   input wire logic phy_tx_valid,
   input wire logic phy_tx_last,
   input wire logic phy_tx_ready,
   input wire logic [7:0] phy_rx_data,
   input wire logic phy_rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_last,
   input wire logic rx_ready,
   input wire logic rx_drop
);
   logic acc;
   logic [7:0] pos_q;
   logic [6:0] len_q;
   assign acc = phy_tx_valid && phy_tx_ready;
   // ==========================================================
   // Byte position within the frame on the air
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pos_q <= 8'h00;
         len_q <= 7'h00;
      end else if (acc) begin
         pos_q <= phy_tx_last ? 8'h00 : pos_q + 8'h01;
         len_q <= (pos_q == 8'h05) ? phy_tx_data[6:0] : len_q;
      end
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Properties
   tx_hold_a: assert property (phy_tx_valid && !phy_tx_ready |=> phy_tx_valid && $stable(phy_tx_data))
      else $error("radio byte not held");
   rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_last))
      else $error("host byte not held");
   pre_zero_a: assert property (acc && pos_q < 8'h04 |-> phy_tx_data == PREAMBLE_BYTE)
      else $error("preamble byte wrong");
   sfd_byte_a: assert property (acc && pos_q == 8'h04 |-> phy_tx_data == SFD_BYTE)
      else $error("start byte wrong");
   frame_end_a: assert property (acc && phy_tx_last |-> pos_q == ((len_q < 7'h02) ? 7'h02 : len_q) + 8'h05)
      else $error("frame end misplaced");
   ready_pre_a: assert property (tx_ready |-> !(phy_tx_valid && pos_q < 8'h05))
      else $error("host taken during header");
   drop_pulse_a: assert property (rx_drop |=> !rx_drop)
      else $error("drop longer than a cycle");
   last_valid_a: assert property (rx_last |-> rx_valid)
      else $error("last without valid");
endmodule : ifp_frame_path_properties
bind ifp_frame_path ifp_frame_path_properties ifp_frame_path_properties_i (.clock(clock), .rst_n(rst_n),
   .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .phy_tx_data(phy_tx_data),
   .phy_tx_valid(phy_tx_valid), .phy_tx_last(phy_tx_last), .phy_tx_ready(phy_tx_ready), .phy_rx_data(phy_rx_data),
   .phy_rx_valid(phy_rx_valid), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
   .rx_drop(rx_drop));

// >>> dv/ifp_radio_model.sv
// Radio side model of the frame path
`timescale 1ns/10ps
module ifp_radio_model
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] phy_tx_data,
   input wire logic phy_tx_valid,
   input wire logic phy_tx_last,
   output logic phy_tx_ready,
   output logic [7:0] phy_rx_data,
   output logic phy_rx_valid
);
   logic [7:0] txq[$];
   int last_pos;
   int k;
   initial begin
      phy_tx_ready = 0;
      phy_rx_valid = 0;
      phy_rx_data = 8'h5a;
   end
   // Settled mid-cycle view of the handshake taken at the next rising edge
   always @(negedge clock) begin
      if (rst_n && phy_tx_valid && phy_tx_ready) begin
         txq.push_back(phy_tx_data);
         last_pos = phy_tx_last ? txq.size() : last_pos;
      end
   end
   // Stall one cycle in four so held bytes get exercised
   always @(posedge clock) begin
      k++;
      #1 phy_tx_ready = (k % 4 != 1);
   end
   // Idle line shows the inverse byte, never a stale copy
   task send_byte(input logic [7:0] b);
      @(posedge clock);
      #1 phy_rx_valid = 1;
      phy_rx_data = b;
      @(posedge clock);
      #1 phy_rx_valid = 0;
      phy_rx_data = ~b;
   endtask : send_byte
endmodule : ifp_radio_model

// >>> dv/tb_top.sv
// Self-checking bench of the frame path
`timescale 1ns/10ps
module tb_top
   import ifp_pkg::*;
;
   logic clock, rst_n, tx_valid, tx_ready, ptv, ptl, ptr, prv, rx_valid, rx_last, rx_ready, rx_drop;
   logic [7:0] tx_data, ptd, prd, rx_data, seq_q;
   logic [31:0] ctr_q;
   logic [7:0] fr[$];
   logic [7:0] rxq[$];
   int fail_count, num_checks, cyc, drops, rx_end;
   ifp_frame_path ifp_frame_path_i (.clock(clock), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .phy_tx_data(ptd), .phy_tx_valid(ptv), .phy_tx_last(ptl), .phy_tx_ready(ptr),
      .phy_rx_data(prd), .phy_rx_valid(prv), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
      .rx_ready(rx_ready), .rx_drop(rx_drop));
   ifp_radio_model ifp_radio_model_i (.clock(clock), .rst_n(rst_n), .phy_tx_data(ptd), .phy_tx_valid(ptv),
      .phy_tx_last(ptl), .phy_tx_ready(ptr), .phy_rx_data(prd), .phy_rx_valid(prv));
   // ==========================================================
   // Helpers
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Reflected register from zero, bit 0 of each byte first
   function automatic logic [15:0] crc();
      logic [15:0] c;
      c = CRC_INIT;
      foreach (fr[i])
         for (int j = 0; j < 8; j++)
            c = (c[0] ^ fr[i][j]) ? (c >> 1) ^ CRC_POLY_REV : c >> 1;
      return c;
   endfunction : crc
   // Host-built frame of length n: broadcast data header when n is above 2, payload, no sum
   task mk(input int n);
      fr = {8'(n)};
      if (n > 2) begin
         fr = {fr, REF_FRAME_CTRL[7:0], REF_FRAME_CTRL[15:8], seq_q};
         fr = {fr, REF_BCAST[7:0], REF_BCAST[15:8], REF_BCAST[7:0], REF_BCAST[15:8]};
         seq_q++;
      end
      if (n == REF_LEN_SEC_DATA) begin
         // Source identifier value is arbitrary
         fr = {fr, REF_PAYLOAD_CTRL[7:0], REF_PAYLOAD_CTRL[15:8], 8'h11, 8'h22, 8'h33, 8'h44};
         fr = {fr, ctr_q[7:0], ctr_q[15:8], ctr_q[23:16], ctr_q[31:24]};
         // Command byte, then a fixed stand-in signature: the path never checks it
         fr = {fr, 8'h01, 8'h5e, 8'h3c, 8'h96, 8'h0d};
         ctr_q++;
      end
      while (fr.size() < n - 1)
         fr.push_back(8'(fr.size() * 37 + 1));
   endtask : mk
   task conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   // ==========================================================
   // Scenarios
   task tx_test(input int n);
      logic [15:0] c;
      logic [7:0] q[$];
      mk(n);
      c = crc();
      q = {PREAMBLE_BYTE, PREAMBLE_BYTE, PREAMBLE_BYTE, PREAMBLE_BYTE, SFD_BYTE, fr, c[7:0], c[15:8]};
      // Ready is judged settled, so the next rising edge is the one that takes
      foreach (fr[i]) begin
         tx_data = fr[i];
         tx_valid = 1;
         while (tx_ready !== 1'b1) begin
            @(posedge clock);
            #1;
         end
         @(posedge clock);
         #1;
      end
      tx_valid = 0;
      while (ifp_radio_model_i.txq.size() < n + 6) @(posedge clock);
      #1;
      foreach (q[i]) check("radio byte", 16'(ifp_radio_model_i.txq[i]), 16'(q[i]));
      check("radio last", 16'(ifp_radio_model_i.last_pos), 16'(n + 6));
      ifp_radio_model_i.txq = {};
      $display("transmit length %0d done", n);
   endtask : tx_test
   // Bad frames must vanish; good ones reach the host without framing
   task rx_test(input int n, input logic bad);
      logic [15:0] c;
      logic [7:0] q[$];
      mk(n);
      c = crc() ^ 16'(bad);
      q = {PREAMBLE_BYTE, SFD_BYTE, fr, c[7:0], c[15:8]};
      rxq = {};
      drops = 0;
      foreach (q[i]) ifp_radio_model_i.send_byte(q[i]);
      for (int t = 0; t < 300 && rxq.size() < n - 1 && drops == 0; t++) @(posedge clock);
      repeat (6) @(posedge clock);
      #1;
      check("drops", 16'(drops), 16'(bad));
      check("host count", 16'(rxq.size()), bad ? 16'h0000 : 16'(n - 1));
      for (int i = 0; i < rxq.size(); i++) check("host byte", 16'(rxq[i]), 16'(fr[i]));
      if (!bad) check("host last", 16'(rx_end), 16'(n - 1));
      $display("receive length %0d done", n);
   endtask : rx_test
   // ==========================================================
   // Clock, host sink and run
   initial begin
      clock = 0;
      forever #20 clock = ~clock;
   end
   // Mid-cycle sampling sees each host handshake once, settled
   always @(negedge clock) begin
      cyc++;
      if (rx_valid && rx_ready) rxq.push_back(rx_data);
      if (rx_valid && rx_ready && rx_last) rx_end = rxq.size();
      if (rx_drop) drops++;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   // Long host stalls fill the two-entry buffer
   always @(posedge clock) #1 rx_ready = (cyc % 16 > 5);
   initial begin
      rst_n = 0;
      tx_valid = 0;
      tx_data = 8'h00;
      rx_ready = 0;
      seq_q = 8'h00;
      ctr_q = 32'h00000001;
      repeat (5) @(posedge clock);
      #1 rst_n = 1;
      tx_test(2);
      tx_test(REF_LEN_STD_DATA);
      tx_test(REF_LEN_SEC_DATA);
      rx_test(REF_LEN_SEC_COMM, 0);
      rx_test(REF_LEN_STD_COMM, 1);
      rx_test(2, 0);
      // Length below two is refused and dropped
      rx_test(1, 1);
      conclude();
   end
endmodule : tb_top
